// ===== bench/waveform_setpoint_generator_test.sv
// Self-checking bench for the waveform set-value generator
`timescale 1ns/1ps
`default_nettype none
`include "wsg_map.svh"
module waveform_setpoint_generator_test;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [2:0] btn = 3'h0;
	logic [1:0] alm = 2'h0;
	logic [1:0] trip = 2'h0;
	logic [1:0] unav = 2'h0;
	logic [15:0] set_voltage;
	logic [16:0] set_current;
	logic [15:0] set_power;
	logic dc_output_on;
	logic alarm_report;
	logic waveform_running;
	logic opt;
	logic oct;
	logic [15:0] out_v;
	logic [31:0] rdat;
	logic [31:0] ctl;
	logic [15:0] vmin;
	logic [15:0] vmax;
	logic signed [16:0] imin;
	logic signed [16:0] imax;
	int hcnt;
	int n_fail = 0;
	int n_checks = 0;

	always #10 pclk = ~pclk;

	wsg_top #(.TICK_CYCLES(16'h0020)) u_wsg_top (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .start_btn(btn[0]),
		.stop_btn(btn[1]), .toggle_btn(btn[2]), .unit_alarm(alm[0]),
		.over_power_trip(opt), .over_current_trip(oct),
		.event_alarm(alm[1]), .slave_mode(unav[0]),
		.resistance_mode(unav[1]), .set_voltage(set_voltage),
		.set_current(set_current), .set_power(set_power),
		.dc_output_on(dc_output_on), .alarm_report(alarm_report),
		.waveform_running(waveform_running));

	wsg_stage_model u_wsg_stage_model (.pclk(pclk),
		.dc_output_on(dc_output_on), .set_voltage(set_voltage),
		.trip_req(trip), .over_power_trip(opt), .over_current_trip(oct),
		.out_v(out_v));

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (e !== g)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge pclk);
			i++;
		end
		while (pready !== 1'b1 && i < 20);
		rdat = prdata;
		if (i >= 20)
		begin
			n_fail++;
			conclude();
		end
		chk("pslverr", {31'h0, a > 8'h2c}, {31'h0, pslverr});
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge so the next call never redrives psel in this step
		@(posedge pclk);
	endtask : apb

	task automatic cmd(input logic [31:0] c);
		apb(1'b1, `WSG_A_CTRL, ctl | c);
		repeat (3) @(posedge pclk);
	endtask : cmd

	// Pins pass a synchroniser, so hold them a few cycles
	task automatic press(input int k);
		btn[k] <= 1'b1;
		repeat (4) @(posedge pclk);
		btn[k] <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask : press

	task automatic st(input logic r, input logic o);
		chk("waveform_running", {31'h0, r}, {31'h0, waveform_running});
		chk("dc_output_on", {31'h0, o}, {31'h0, dc_output_on});
	endtask : st

	task automatic setup(input logic [31:0] c, a, o, t1, t2);
		ctl = c;
		apb(1'b1, `WSG_A_CTRL, c);
		apb(1'b1, `WSG_A_AMP, a);
		apb(1'b1, `WSG_A_OFFS, o);
		apb(1'b1, `WSG_A_T1, t1);
		apb(1'b1, 8'h18, t2);
		apb(1'b1, 8'h1c, t1);
		apb(1'b1, `WSG_A_T4, t2);
	endtask : setup

	task automatic watch(input int n, input logic [15:0] hv);
		vmin = 16'hffff;
		vmax = 16'h0000;
		imin = 17'h0_ffff;
		imax = 17'h1_0000;
		hcnt = 0;
		repeat (n)
		begin
			@(posedge pclk);
			if (set_voltage < vmin) vmin = set_voltage;
			if (set_voltage > vmax) vmax = set_voltage;
			if ($signed(set_current) < imin) imin = $signed(set_current);
			if ($signed(set_current) > imax) imax = $signed(set_current);
			if (set_voltage === hv) hcnt++;
		end
	endtask : watch

	task automatic s_rect();
		setup(32'h0000_0200, 32'h0000_0064, 32'h0000_0032, 32'h2, 32'h3);
		apb(1'b1, `WSG_A_SV, 32'h0000_0007);
		apb(1'b1, `WSG_A_SP, 32'h0000_0009);
		apb(1'b1, 8'h40, 32'h0000_0001);
		cmd(32'h0000_0008);
		st(1'b0, 1'b1);
		chk("set_voltage", 32'h0000_0007, 32'(set_voltage));
		chk("stage_v", 32'h0000_0007, 32'(out_v));
		cmd(32'h0000_0001);
		st(1'b1, 1'b1);
		repeat (200) @(posedge pclk);
		watch(320, 16'h0096);
		chk("pulse_level", 32'h0000_0096, 32'(vmax));
		chk("pause_level", 32'h0000_0032, 32'(vmin));
		chk("pulse_cycles", 32'd128, 32'(hcnt));
		chk("set_power", 32'h0000_0009, 32'(set_power));
		press(1);
		st(1'b0, 1'b1);
		chk("held_level", 32'h0000_0007, 32'(set_voltage));
		press(0);
		st(1'b1, 1'b1);
		press(2);
		st(1'b0, 1'b0);
		chk("stage_off", 32'h0000_0000, 32'(out_v));
		press(2);
		st(1'b1, 1'b1);
		press(2);
		cmd(32'h0000_0001);
		st(1'b1, 1'b1);
	endtask : s_rect

	task automatic s_alarm();
		for (int k = 0; k < 4; k++)
		begin
			press(0);
			st(1'b1, 1'b1);
			if (k < 2) alm[k] <= 1'b1;
			else trip[k-2] <= 1'b1;
			repeat (6) @(posedge pclk);
			st(1'b0, 1'b0);
			chk("alarm_report", 32'h1, {31'h0, alarm_report});
			alm <= 2'h0;
			trip <= 2'h0;
			repeat (4) @(posedge pclk);
			cmd(32'h0000_0010);
			chk("alarm_clear", 32'h0, {31'h0, alarm_report});
		end
	endtask : s_alarm

	task automatic s_trap();
		setup(32'h0000_1300, 32'h0000_00c8, 32'hffff_ff9c, 32'h2, 32'h2);
		apb(1'b1, `WSG_A_SI, 32'h0000_0005);
		apb(1'b1, `WSG_A_SV, 32'h0000_012c);
		cmd(32'h0000_0009);
		repeat (300) @(posedge pclk);
		watch(512, 16'h012c);
		chk("top_level", 32'h0000_0064, 32'(imax));
		chk("base_level", 32'hffff_ff9c, 32'(imin));
		chk("fixed_voltage", 32'd512, 32'(hcnt));
		cmd(32'h0000_0002);
		st(1'b0, 1'b1);
		chk("held_current", 32'h0000_0005, 32'(set_current));
	endtask : s_trap

	task automatic s_unav();
		for (int m = 0; m < 2; m++)
		begin
			press(0);
			unav[m] <= 1'b1;
			repeat (6) @(posedge pclk);
			st(1'b0, 1'b1);
			press(0);
			st(1'b0, 1'b1);
			unav[m] <= 1'b0;
			repeat (4) @(posedge pclk);
		end
	endtask : s_unav

	task automatic s_sine();
		apb(1'b1, `WSG_A_FREQ, 32'h0000_3a98);
		apb(1'b0, `WSG_A_FREQ, 32'h0000_0000);
		chk("freq_clamp", 32'h0000_2710, rdat);
		setup(32'h0000_0000, 32'h0000_03e8, 32'h0000_1388, 32'h1, 32'h1);
		cmd(32'h0000_0001);
		watch(5000, 16'h0000);
		chk("sine_top", 32'h1, {31'h0, vmax <= 6000 && vmax >= 5900});
		chk("sine_foot", 32'h1, {31'h0, vmin >= 4000 && vmin <= 4100});
		cmd(32'h0000_0002);
	endtask : s_sine

	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, `WSG_A_T1, 32'h0000_0000);
		chk("tseg_reset", 32'h0000_0001, rdat);
		s_rect();
		s_alarm();
		s_trap();
		s_unav();
		s_sine();
		conclude();
	end
endmodule : waveform_setpoint_generator_test
`default_nettype wire

// ===== bench/wsg_stage_model.sv
// Power stage model: follows the set value, raises trips on request
`timescale 1ns/1ps
`default_nettype none
module wsg_stage_model (
	// Clock
	input wire logic pclk,
	// Set values from the generator, trip requests from the bench
	input wire logic dc_output_on,
	input wire logic [15:0] set_voltage,
	input wire logic [1:0] trip_req,
	// Trips and regulated output
	output logic over_power_trip,
	output logic over_current_trip,
	output logic [15:0] out_v
);
	// Output drops to zero when disabled, never keeps the last value
	always_ff @(posedge pclk)
	begin
		out_v <= dc_output_on ? set_voltage : 16'h0000;
		over_power_trip <= trip_req[0];
		over_current_trip <= trip_req[1];
	end
endmodule : wsg_stage_model
`default_nettype wire

// ===== common/wsg_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef WSG_MAP_SVH
`define WSG_MAP_SVH
`define WSG_A_CTRL 8'h00
`define WSG_A_STATUS 8'h04
`define WSG_A_AMP 8'h08
`define WSG_A_OFFS 8'h0c
`define WSG_A_FREQ 8'h10
`define WSG_A_T1 8'h14
`define WSG_A_T4 8'h20
`define WSG_A_SV 8'h24
`define WSG_A_SI 8'h28
`define WSG_A_SP 8'h2c
`define WSG_B_START 0
`define WSG_B_STOP 1
`define WSG_B_TOGGLE 2
`define WSG_B_LOAD 3
`define WSG_B_CLRALM 4
`define WSG_B_SHAPE 8
`define WSG_B_TARGET 12
`define WSG_RST_FREQ 14'h0001
`define WSG_RST_T 29'h0000_0001
`define WSG_T_MIN 29'h0000_0001
`define WSG_T_MAX 29'h1575_2a00
`define WSG_F_MIN 14'h0001
`define WSG_F_MAX 14'h2710
`define WSG_PH_K 32'h0001_5799
`define WSG_RATED 18'h0_ffff
`define WSG_CLK_NS 20
`define WSG_TICK_NS 100000
`define WSG_TICK_CYC ((`WSG_TICK_NS + `WSG_CLK_NS - 1) / `WSG_CLK_NS)
`endif

// ===== common/wsg_pkg.sv
// Types of the waveform set-value generator
package wsg_pkg;
	typedef enum logic [2:0] {
		WSG_OFF = 3'b001,
		WSG_HOLD = 3'b010,
		WSG_RUN = 3'b100
	} wsg_state_t;
	typedef enum logic [1:0] {
		WSG_SINE = 2'h0,
		WSG_TRI = 2'h1,
		WSG_RECT = 2'h2,
		WSG_TRAP = 2'h3
	} wsg_shape_t;
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		wsg_shape_t shape;
		logic target;
		logic [15:0] amp;
		logic [16:0] offs;
		logic [13:0] freq;
		logic [3:0][28:0] tseg;
		logic [15:0] static_v;
		logic [16:0] static_i;
		logic [15:0] static_p;
		logic [8:0] s1;
		logic [8:0] s2;
		logic [2:0] bd;
		wsg_state_t state;
		logic alarm;
		logic [1:0] seg;
		logic [28:0] elapsed;
		logic [15:0] tcnt;
		logic [31:0] phase;
		logic [47:0] rem;
		logic [15:0] q;
		logic [4:0] divi;
		logic [15:0] frac;
		logic [15:0] amp_eff;
		logic [15:0] set_v;
		logic [16:0] set_i;
		logic [15:0] set_p;
		logic on;
		logic run_o;
	} wsg_st_t;
endpackage : wsg_pkg

// ===== rtl/wsg_top.sv
// Waveform set-value generator with run control and APB registers
`timescale 1ns/1ps
`default_nettype none
`include "wsg_map.svh"
module wsg_top
	import wsg_pkg::*;
#(
	parameter logic [15:0] TICK_CYCLES = 16'(`WSG_TICK_CYC)
)(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Local controls and unit status pins
	input wire logic start_btn,
	input wire logic stop_btn,
	input wire logic toggle_btn,
	input wire logic unit_alarm,
	input wire logic over_power_trip,
	input wire logic over_current_trip,
	input wire logic event_alarm,
	input wire logic slave_mode,
	input wire logic resistance_mode,
	// Power stage set values, output enable and status outputs
	output logic [15:0] set_voltage,
	output logic [16:0] set_current,
	output logic [15:0] set_power,
	output logic dc_output_on,
	output logic alarm_report,
	output logic waveform_running
);
	// Out-of-range requests settle on the nearest legal frequency
	function automatic logic [13:0] clamp_f(input logic [13:0] f);
		if (f < `WSG_F_MIN)
			clamp_f = `WSG_F_MIN;
		else if (f > `WSG_F_MAX)
			clamp_f = `WSG_F_MAX;
		else
			clamp_f = f;
	endfunction : clamp_f

	function automatic logic [28:0] clamp_t(input logic [28:0] t);
		if (t < `WSG_T_MIN)
			clamp_t = `WSG_T_MIN;
		else if (t > `WSG_T_MAX)
			clamp_t = `WSG_T_MAX;
		else
			clamp_t = t;
	endfunction : clamp_t

	// Voltage floors at zero, current may go negative (sink)
	function automatic logic [16:0] clamp_set(input logic signed [17:0] v,
		input logic cur);
		logic signed [17:0] hi;
		logic signed [17:0] lo;
		hi = $signed(`WSG_RATED);
		lo = cur ? -hi : 18'sh0_0000;
		if (v > hi)
			clamp_set = hi[16:0];
		else if (v < lo)
			clamp_set = lo[16:0];
		else
			clamp_set = v[16:0];
	endfunction : clamp_set

	// Parabolic half-wave, peak error near 6 percent, no table needed
	function automatic logic [15:0] sine_mag(input logic [31:0] ph);
		logic [31:0] m;
		m = 32'(ph[30:15]) * 32'(~ph[30:15]);
		sine_mag = m[29:14];
	endfunction : sine_mag

	// 0 rise, 1 top, 2 fall, 3 base
	function automatic logic [1:0] seg_kind(input wsg_shape_t s,
		input logic [1:0] g);
		if (s == WSG_TRI)
			seg_kind = g[0] ? 2'h2 : 2'h0;
		else if (s == WSG_RECT)
			seg_kind = g[0] ? 2'h3 : 2'h1;
		else
			seg_kind = g;
	endfunction : seg_kind

	wsg_st_t st;
	wsg_st_t n;
	logic acc, wr, wr_ctrl, alarm_any, unavail, tick, last_seg;
	logic cmd_start, cmd_stop, cmd_toggle, cmd_load;
	logic [2:0] rise;
	logic [28:0] tcur;
	logic [31:0] inc;
	logic [47:0] inc_w;
	logic [16:0] abs_offs, lim, level, hi_lvl, wave;
	logic [31:0] smul;

	assign acc = psel & penable & st.pready;
	assign wr = acc & pwrite;
	assign wr_ctrl = wr && paddr == `WSG_A_CTRL;
	assign rise = st.s2[2:0] & ~st.bd;
	assign alarm_any = |st.s2[6:3];
	assign unavail = st.s2[7] | st.s2[8];
	assign cmd_start = (wr_ctrl & pwdata[`WSG_B_START]) | rise[0];
	assign cmd_stop = (wr_ctrl & pwdata[`WSG_B_STOP]) | rise[1];
	assign cmd_toggle = (wr_ctrl & pwdata[`WSG_B_TOGGLE]) | rise[2];
	assign cmd_load = wr_ctrl & pwdata[`WSG_B_LOAD];
	assign tick = st.tcnt == TICK_CYCLES - 16'h0001;
	assign tcur = clamp_t(st.tseg[st.seg]);
	assign last_seg = st.seg == (st.shape == WSG_TRAP ? 2'h3 : 2'h1);
	assign inc_w = 48'(clamp_f(st.freq)) * 48'(`WSG_PH_K);
	// Step constant holds ten fraction bits; 1 Hz truncates to a step of 85, just over one percent slow
	assign inc = inc_w[41:10];
	assign abs_offs = st.offs[16] ? 17'(-st.offs) : st.offs;
	assign lim = 17'(`WSG_RATED) - abs_offs;
	assign smul = 32'(st.amp_eff) * 32'(sine_mag(st.phase));
	always_comb
	begin
		level = 17'h0_0000;
		if (st.shape == WSG_SINE)
			level = st.phase[31] ? 17'(-{1'b0, smul[31:16]})
				: {1'b0, smul[31:16]};
		else if (seg_kind(st.shape, st.seg) == 2'h0)
			level = {1'b0, st.frac};
		else if (seg_kind(st.shape, st.seg) == 2'h1)
			level = {1'b0, st.amp_eff};
		else if (seg_kind(st.shape, st.seg) == 2'h2)
			level = {1'b0, st.amp_eff - st.frac};
	end
	assign wave = clamp_set($signed({st.offs[16], st.offs}) +
		$signed({level[16], level}), st.target);
	assign hi_lvl = clamp_set($signed({st.offs[16], st.offs}) +
		$signed({2'b00, st.amp_eff}), st.target);

	always_comb
	begin
		logic do_start;
		logic [47:0] trial;
		logic ge;
		logic [1:0] idx;
		do_start = 1'b0;
		trial = 48'h0000_0000_0000;
		ge = 1'b0;
		idx = 2'(8'(paddr - `WSG_A_T1) >> 2);
		n = st;
		n.s1 = {resistance_mode, slave_mode, event_alarm, over_current_trip,
			over_power_trip, unit_alarm, toggle_btn, stop_btn, start_btn};
		n.s2 = st.s1;
		n.bd = st.s2[2:0];
		// One wait state keeps pready and prdata straight from flops
		n.pready = psel & penable & ~st.pready;
		n.pslverr = 1'b0;
		n.prdata = 32'h0000_0000;
		if (paddr == `WSG_A_CTRL)
			n.prdata = {19'h0_0000, st.target, 2'h0, st.shape, 8'h00};
		else if (paddr == `WSG_A_STATUS)
			n.prdata = {22'h00_0000, st.seg, 3'h0, unavail, st.alarm,
				st.state};
		else if (paddr == `WSG_A_AMP)
			n.prdata = {16'h0000, st.amp};
		else if (paddr == `WSG_A_OFFS)
			n.prdata = {{15{st.offs[16]}}, st.offs};
		else if (paddr == `WSG_A_FREQ)
			n.prdata = {18'h0_0000, st.freq};
		else if (paddr >= `WSG_A_T1 && paddr <= `WSG_A_T4 && paddr[1:0] == 2'h0)
			n.prdata = {3'h0, st.tseg[idx]};
		else if (paddr == `WSG_A_SV)
			n.prdata = {16'h0000, st.static_v};
		else if (paddr == `WSG_A_SI)
			n.prdata = {{15{st.static_i[16]}}, st.static_i};
		else if (paddr == `WSG_A_SP)
			n.prdata = {16'h0000, st.static_p};
		else
			n.pslverr = 1'b1;
		// Shape settings frozen while running so a run never mixes them
		if (wr && st.state != WSG_RUN)
		begin
			if (paddr == `WSG_A_CTRL)
			begin
				n.shape = wsg_shape_t'(pwdata[`WSG_B_SHAPE+:2]);
				n.target = pwdata[`WSG_B_TARGET];
			end
			else if (paddr == `WSG_A_AMP)
				n.amp = pwdata[15:0];
			else if (paddr == `WSG_A_OFFS)
				n.offs = pwdata[16:0];
			else if (paddr == `WSG_A_FREQ)
				n.freq = clamp_f(pwdata[13:0]);
			else if (paddr >= `WSG_A_T1 && paddr <= `WSG_A_T4 &&
				paddr[1:0] == 2'h0)
				n.tseg[idx] = pwdata[28:0];
			else if (paddr == `WSG_A_SV)
				n.static_v = pwdata[15:0];
			else if (paddr == `WSG_A_SI)
				n.static_i = pwdata[16:0];
			else if (paddr == `WSG_A_SP)
				n.static_p = pwdata[15:0];
		end
		if (wr_ctrl && pwdata[`WSG_B_CLRALM])
			n.alarm = 1'b0;
		if (alarm_any)
		begin
			n.alarm = 1'b1;
			n.state = WSG_OFF;
		end
		else if (unavail)
		begin
			if (st.state == WSG_RUN)
				n.state = WSG_HOLD;
		end
		else if (cmd_toggle)
		begin
			if (st.state == WSG_OFF)
				do_start = 1'b1;
			else
				n.state = WSG_OFF;
		end
		else if (cmd_stop)
		begin
			if (st.state == WSG_RUN)
				n.state = WSG_HOLD;
		end
		else if (cmd_start)
			do_start = 1'b1;
		else if (cmd_load && st.state == WSG_OFF)
			n.state = WSG_HOLD;
		if (do_start)
		begin
			n.state = WSG_RUN;
			n.seg = 2'h0;
			n.elapsed = 29'h0000_0000;
			n.tcnt = 16'h0000;
			n.phase = 32'h0000_0000;
			n.frac = 16'h0000;
			n.divi = 5'h00;
			n.amp_eff = ({1'b0, st.amp} > lim) ? lim[15:0] : st.amp;
		end
		else if (st.state == WSG_RUN)
		begin
			n.phase = st.phase + inc;
			n.tcnt = tick ? 16'h0000 : st.tcnt + 16'h0001;
			if (tick && st.shape != WSG_SINE)
			begin
				if (st.elapsed + 29'h0000_0001 >= tcur)
				begin
					n.elapsed = 29'h0000_0000;
					n.seg = last_seg ? 2'h0 : st.seg + 2'h1;
					n.frac = 16'h0000;
				end
				else
					n.elapsed = st.elapsed + 29'h0000_0001;
				// Serial divide: ramp = amp * elapsed / segment time
				n.rem = 48'(st.amp_eff) * 48'(n.elapsed);
				n.q = 16'h0000;
				n.divi = 5'h10;
			end
			else if (st.divi != 5'h00)
			begin
				trial = 48'(tcur) << (st.divi - 5'h01);
				ge = st.rem >= trial;
				n.rem = ge ? st.rem - trial : st.rem;
				n.q = {st.q[14:0], ge};
				n.divi = st.divi - 5'h01;
				if (st.divi == 5'h01)
					n.frac = {st.q[14:0], ge};
			end
		end
		n.set_v = (n.state == WSG_RUN && !st.target) ? wave[15:0]
			: st.static_v;
		n.set_i = (n.state == WSG_RUN && st.target) ? wave
			: st.static_i;
		n.set_p = st.static_p;
		n.on = n.state != WSG_OFF;
		n.run_o = n.state == WSG_RUN;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= '0;
			st.state <= WSG_OFF;
			st.freq <= `WSG_RST_FREQ;
			st.tseg <= {4{`WSG_RST_T}};
		end
		else
			st <= n;
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign set_voltage = st.set_v;
	assign set_current = st.set_i;
	assign set_power = st.set_p;
	assign dc_output_on = st.on;
	assign alarm_report = st.alarm;
	assign waveform_running = st.run_o;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_clean;
		!alarm_any && !unavail;
	endsequence
	sequence s_start_off;
		s_clean and (st.state == WSG_OFF && cmd_start && !cmd_toggle &&
			!cmd_stop);
	endsequence
	property p_start;
		s_clean and (cmd_start && !cmd_toggle && !cmd_stop) |=>
			st.state == WSG_RUN && waveform_running;
	endproperty
	a_start: assert property (p_start) else $error("start did not run");
	property p_start_on;
		s_start_off |=> dc_output_on && st.elapsed == 29'h0000_0000;
	endproperty
	a_start_on: assert property (p_start_on) else $error("output not on");
	property p_stop;
		s_clean and (st.state == WSG_RUN && cmd_stop && !cmd_toggle) |=>
			st.state == WSG_HOLD && dc_output_on &&
			(st.target || set_voltage == $past(st.static_v));
	endproperty
	a_stop: assert property (p_stop) else $error("stop not held");
	property p_toggle;
		s_clean and (st.state == WSG_RUN && cmd_toggle) |=>
			st.state == WSG_OFF && !dc_output_on;
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle left on");
	property p_alarm;
		alarm_any |=> !dc_output_on && alarm_report && !waveform_running;
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm not handled");
	property p_phase;
		(st.state == WSG_RUN && st.shape == WSG_SINE && !cmd_start) ##1
			st.state == WSG_RUN |-> st.phase == $past(st.phase) + $past(inc);
	endproperty
	a_phase: assert property (p_phase) else $error("phase step wrong");
	property p_tri_segs;
		st.state == WSG_RUN && st.shape == WSG_TRI |-> st.seg <= 2'h1;
	endproperty
	a_tri_segs: assert property (p_tri_segs) else $error("bad tri seg");
	property p_seg_order;
		st.state == WSG_RUN && $past(st.state) == WSG_RUN &&
			st.seg != $past(st.seg) |-> st.seg == 2'h0 ||
			st.seg == $past(st.seg) + 2'h1;
	endproperty
	a_seg_order: assert property (p_seg_order) else $error("seg skip");
	property p_rect_hi;
		st.state == WSG_RUN && st.shape == WSG_RECT && st.seg == 2'h0 &&
			!st.target ##1 st.state == WSG_RUN |->
			set_voltage == $past(hi_lvl[15:0]);
	endproperty
	a_rect_hi: assert property (p_rect_hi) else $error("pulse level");
	property p_unavail;
		unavail |=> !waveform_running;
	endproperty
	a_unavail: assert property (p_unavail) else $error("ran unavailable");
	property p_load;
		s_clean and (st.state == WSG_OFF && cmd_load && !cmd_start &&
			!cmd_stop && !cmd_toggle) |=> dc_output_on &&
			set_voltage == $past(st.static_v);
	endproperty
	a_load: assert property (p_load) else $error("load not applied");
	property p_limits;
		st.state == WSG_RUN && !st.target |=>
			set_current == $past(st.static_i) && set_power == $past(st.static_p);
	endproperty
	a_limits: assert property (p_limits) else $error("limit moved");
endmodule : wsg_top
`default_nettype wire
